// ### src/pef_pkg.sv
// Constants, register map and field layout of the power event flag block.
// Summary of operation
// - Flag bit 7 sets when the switched supply returns from battery to main.
// - Flag bit 6 sets whenever an enabled power event occurs.
// - Flag bit 5 sets when the metering section reports a voltage sag.
// - Flag bit 1 sets when the switched supply moves from main to battery.
// - Flag bit 0 sets when the DC input comparator reports below 1.2 V.
// - Policy 00 switches on low main, 01 also on low DC, 1x never.
// - Peripheral bit 7 sets when a receive edge woke the deepest sleep mode.
// - Peripheral bit 6 reads the switched source, 1 for main, resets to 1.
// - Peripheral bit 5 reads 1 while the main supply is ready, resets to 1.
// - Peripheral bit 4 sets on PLL lock loss, cleared by the acknowledge bit.
// - Receive field 00 selects GPIO, 01 serial, 11 serial with edge wake-up.
// - Enable bits 7 and 5 let restore and sag flags raise the interrupt.
// - Enable bits 1 and 0 let battery and DC flags raise the interrupt.
// - Flags and enables reset to 0, policy and receive fields to 00.
// - Registers sit at special function addresses EC, F5, F8 and F4.
package pef_pkg;
  // ****************************************
  // Register addresses.
  // ****************************************
  localparam logic [7:0] ADDR_ENABLE = 8'hEC;
  localparam logic [7:0] ADDR_PERIPHERAL_STATUS_CONFIG = 8'hF4;
  localparam logic [7:0] ADDR_POLICY = 8'hF5;
  localparam logic [7:0] ADDR_FLAGS = 8'hF8;
  localparam logic [7:0] ADDR_MEAS_START = 8'hD8;
  localparam logic [4:0] FLAGS_BIT_BASE = 5'h1F;
  localparam int PLL_ACK_BIT = 6;
  // ****************************************
  // Field positions.
  // ****************************************
  localparam int FL_RESTORED = 7;
  localparam int FL_PSM = 6;
  localparam int FL_SAG = 5;
  localparam int FL_BATTERY = 1;
  localparam int FL_DCIN = 0;
  localparam int PE_RX_WAKE = 7;
  localparam int PE_SRC_MAIN = 6;
  localparam int PE_MAIN_OK = 5;
  localparam int PE_PLL_FAULT = 4;
  localparam logic [7:0] ENABLE_MASK = 8'hA3;
  localparam logic [7:0] FLAGS_MASK = 8'hE3;
  // ****************************************
  // Event cell layout and reset values.
  // ****************************************
  localparam int EV_DCIN = 0;
  localparam int EV_BATTERY = 1;
  localparam int EV_SAG = 2;
  localparam int EV_RESTORED = 3;
  localparam int EV_PLL = 4;
  localparam int EV_RX = 5;
  localparam int NUM_EV = 6;
  localparam logic [5:0] EV_FALL = 6'h32;
  localparam logic [5:0] EV_PREV_RST = 6'h3A;
  localparam int NUM_IN = 7;
  localparam logic [6:0] SYNC_RST = 7'h33;
  localparam logic [1:0] RXF_WAKE = 2'h3;
  localparam logic [1:0] FIELD_RST = 2'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// ### src/pef_sync.sv
// Three-stage input synchroniser whose output moves once stages two and three agree.
`timescale 1ns/100ps
module pef_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      out_q <= RST;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule // pef_sync

// ### src/pef_flag.sv
// Sticky event flag set on one edge of its condition and written by software.
`timescale 1ns/100ps
module pef_flag #(
  parameter logic FALL = 1'b0,
  parameter logic PREV_RST = 1'b0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cond,
  input wire logic arm,
  input wire logic wr_en,
  input wire logic wr_val,
  output logic set_p,
  output logic flag_q
);
  logic prev_q, flag_d;

  always_comb begin
    set_p = arm & (FALL ? (prev_q & ~cond) : (cond & ~prev_q));
    flag_d = flag_q;
    if (set_p) begin
      flag_d = 1'b1;
    end else if (wr_en) begin
      flag_d = wr_val;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= PREV_RST;
      flag_q <= 1'b0;
    end else begin
      prev_q <= cond;
      flag_q <= flag_d;
    end
  end
endmodule // pef_flag

// ### src/pef_power_events.sv
// Power event flags, enables, switchover policy and peripheral status registers.
`timescale 1ns/100ps
module pef_power_events
  import pef_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_BIT_WR,
  input wire logic [7:0] SFR_BIT_ADDR,
  input wire logic SFR_BIT_VAL,
  input wire logic SRC_IS_MAIN,
  input wire logic MAIN_SUPPLY_OK,
  input wire logic SAG_DETECT,
  input wire logic DCIN_LOW,
  input wire logic PLL_LOCKED,
  input wire logic RX_PIN,
  input wire logic IN_DEEP_SLEEP,
  output logic [7:0] SFR_RDATA,
  output logic PSM_IRQ,
  output logic SWITCH_ON_LOW_MAIN,
  output logic SWITCH_ON_LOW_DCIN,
  output logic RX_SERIAL_SEL,
  output logic RX_WAKE_EN
);
  // ****************************************
  // Input synchronisers.
  // ****************************************
  logic [NUM_IN-1:0] raw_in, syn;
  logic src_main_s, main_ok_s, sag_s, dcin_s, pll_s, rx_s, deep_s;

  assign raw_in = {IN_DEEP_SLEEP, RX_PIN, PLL_LOCKED, DCIN_LOW, SAG_DETECT, MAIN_SUPPLY_OK, SRC_IS_MAIN};
  assign {deep_s, rx_s, pll_s, dcin_s, sag_s, main_ok_s, src_main_s} = syn;

  pef_sync #(.W(NUM_IN), .RST(SYNC_RST)) u_sync (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .din(raw_in),
    .dout(syn)
  );

  // ****************************************
  // Register write decode.
  // ****************************************
  logic wr_enable, wr_peripheral_status_config, wr_policy, wr_flags, wr_meas, bit_flags;
  logic pll_ack;
  logic [7:0] fl_wr_en, fl_wr_val;

  always_comb begin
    wr_enable = SFR_WR && (SFR_ADDR == ADDR_ENABLE);
    wr_peripheral_status_config = SFR_WR && (SFR_ADDR == ADDR_PERIPHERAL_STATUS_CONFIG);
    wr_policy = SFR_WR && (SFR_ADDR == ADDR_POLICY);
    wr_flags = SFR_WR && (SFR_ADDR == ADDR_FLAGS);
    wr_meas = SFR_WR && (SFR_ADDR == ADDR_MEAS_START);
    bit_flags = SFR_BIT_WR && (SFR_BIT_ADDR[7:3] == FLAGS_BIT_BASE);
    pll_ack = wr_meas && SFR_WDATA[PLL_ACK_BIT];
    fl_wr_en = {8{wr_flags}};
    fl_wr_val = SFR_WDATA;
    if (bit_flags) begin
      fl_wr_en = BYTE_ZERO;
      fl_wr_en[SFR_BIT_ADDR[2:0]] = 1'b1;
      fl_wr_val = {8{SFR_BIT_VAL}};
    end
  end

  // ****************************************
  // Configuration registers.
  // ****************************************
  logic [7:0] en_q, en_d;
  logic [1:0] pol_q, pol_d, rxf_q, rxf_d;
  logic sw_main_q, sw_main_d, sw_dcin_q, sw_dcin_d, rx_ser_q, rx_ser_d, rx_wen_q, rx_wen_d;

  always_comb begin
    en_d = en_q;
    pol_d = pol_q;
    rxf_d = rxf_q;
    if (wr_enable) begin
      en_d = SFR_WDATA & ENABLE_MASK;
    end
    if (wr_policy) begin
      pol_d = SFR_WDATA[1:0];
    end
    if (wr_peripheral_status_config) begin
      rxf_d = SFR_WDATA[1:0];
    end
    sw_main_d = ~pol_d[1];
    sw_dcin_d = ~pol_d[1] & pol_d[0];
    rx_ser_d = rxf_d[0];
    rx_wen_d = (rxf_d == RXF_WAKE);
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      en_q <= BYTE_ZERO;
      pol_q <= FIELD_RST;
      rxf_q <= FIELD_RST;
      sw_main_q <= 1'b1;
      sw_dcin_q <= 1'b0;
      rx_ser_q <= 1'b0;
      rx_wen_q <= 1'b0;
    end else begin
      en_q <= en_d;
      pol_q <= pol_d;
      rxf_q <= rxf_d;
      sw_main_q <= sw_main_d;
      sw_dcin_q <= sw_dcin_d;
      rx_ser_q <= rx_ser_d;
      rx_wen_q <= rx_wen_d;
    end
  end

  // ****************************************
  // Event flag cells.
  // ****************************************
  logic [NUM_EV-1:0] ev_cond, ev_arm, ev_wen, ev_wval, ev_set, ev_flag;

  always_comb begin
    ev_cond = {rx_s, pll_s, src_main_s, sag_s, src_main_s, dcin_s};
    ev_arm = {deep_s && rx_wen_q, 5'h1F};
    ev_wen = {wr_peripheral_status_config, pll_ack, fl_wr_en[FL_RESTORED], fl_wr_en[FL_SAG], fl_wr_en[FL_BATTERY], fl_wr_en[FL_DCIN]};
    ev_wval = {SFR_WDATA[PE_RX_WAKE], 1'b0, fl_wr_val[FL_RESTORED], fl_wr_val[FL_SAG], fl_wr_val[FL_BATTERY],
               fl_wr_val[FL_DCIN]};
  end

  for (genvar g = 0; g < NUM_EV; g++) begin : g_ev
    pef_flag #(.FALL(EV_FALL[g]), .PREV_RST(EV_PREV_RST[g])) u_flag (
      .clk(REF_CLK),
      .arst_n(ARST_N),
      .cond(ev_cond[g]),
      .arm(ev_arm[g]),
      .wr_en(ev_wen[g]),
      .wr_val(ev_wval[g]),
      .set_p(ev_set[g]),
      .flag_q(ev_flag[g])
    );
  end

  // ****************************************
  // Combined power mode flag and interrupt.
  // ****************************************
  logic psm_set, psm_q, psm_d, irq_q;
  logic [7:0] flags_rd;

  always_comb begin
    psm_set = (ev_set[EV_RESTORED] & en_q[FL_RESTORED]) | (ev_set[EV_SAG] & en_q[FL_SAG]) |
              (ev_set[EV_BATTERY] & en_q[FL_BATTERY]) | (ev_set[EV_DCIN] & en_q[FL_DCIN]);
    psm_d = psm_q;
    if (psm_set) begin
      psm_d = 1'b1;
    end else if (fl_wr_en[FL_PSM]) begin
      psm_d = fl_wr_val[FL_PSM];
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      psm_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      psm_q <= psm_d;
      irq_q <= psm_d;
    end
  end

  assign flags_rd = {ev_flag[EV_RESTORED], psm_q, ev_flag[EV_SAG], 3'h0, ev_flag[EV_BATTERY], ev_flag[EV_DCIN]};

  // ****************************************
  // Register read port.
  // ****************************************
  logic [7:0] rd_q, rd_d;

  always_comb begin
    rd_d = rd_q;
    if (SFR_RD) begin
      unique case (SFR_ADDR)
        ADDR_ENABLE: rd_d = en_q;
        ADDR_POLICY: rd_d = {6'h00, pol_q};
        ADDR_FLAGS: rd_d = flags_rd & FLAGS_MASK;
        ADDR_PERIPHERAL_STATUS_CONFIG: rd_d = {ev_flag[EV_RX], src_main_s, main_ok_s, ev_flag[EV_PLL], 2'h0, rxf_q};
        default: rd_d = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rd_q <= BYTE_ZERO;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign SFR_RDATA = rd_q;
  assign PSM_IRQ = irq_q;
  assign SWITCH_ON_LOW_MAIN = sw_main_q;
  assign SWITCH_ON_LOW_DCIN = sw_dcin_q;
  assign RX_SERIAL_SEL = rx_ser_q;
  assign RX_WAKE_EN = rx_wen_q;

  // ****************************************
  // Checks.
  // ****************************************
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!ARST_N);

  chk_restore_flag: assert property ($rose(src_main_s) |=> ev_flag[EV_RESTORED])
    else $error("restore flag not set");
  chk_psm_flag: assert property (ev_set[EV_RESTORED] && en_q[FL_RESTORED] |=> psm_q && PSM_IRQ)
    else $error("combined flag or irq missed");
  chk_psm_quiet: assert property (!psm_q && !psm_set && !fl_wr_en[FL_PSM] |=> !psm_q && !PSM_IRQ)
    else $error("combined flag set without enabled event");
  chk_enable_write: assert property (wr_enable |=> en_q == ($past(SFR_WDATA) & ENABLE_MASK))
    else $error("enable register write wrong");
  chk_dcin_psm: assert property (ev_set[EV_DCIN] && en_q[FL_DCIN] |=> psm_q && PSM_IRQ)
    else $error("dc input event did not raise irq");
  chk_sag_flag: assert property ($rose(sag_s) |=> ev_flag[EV_SAG])
    else $error("sag flag not set");
  chk_battery_flag: assert property ($fell(src_main_s) |=> ev_flag[EV_BATTERY])
    else $error("battery flag not set");
  chk_dcin_flag: assert property ($rose(dcin_s) |=> ev_flag[EV_DCIN])
    else $error("dc input flag not set");
  chk_policy_out: assert property (SWITCH_ON_LOW_MAIN == !pol_q[1] && SWITCH_ON_LOW_DCIN == (pol_q == 2'h1))
    else $error("policy outputs wrong");
  chk_rx_wake: assert property ($fell(rx_s) && deep_s && rx_wen_q |=> ev_flag[EV_RX])
    else $error("receive wake flag not set");
  chk_rx_outputs: assert property (RX_WAKE_EN == (rxf_q == RXF_WAKE) && RX_SERIAL_SEL == rxf_q[0])
    else $error("receive pin outputs wrong");
  chk_src_read: assert property (SFR_RD && SFR_ADDR == ADDR_PERIPHERAL_STATUS_CONFIG |=>
    SFR_RDATA[PE_SRC_MAIN] == $past(src_main_s) && SFR_RDATA[PE_MAIN_OK] == $past(main_ok_s))
    else $error("peripheral status read wrong");
  chk_pll_ack: assert property (pll_ack && !ev_set[EV_PLL] |=> !ev_flag[EV_PLL])
    else $error("pll fault not acknowledged");
  chk_pll_fault: assert property ($fell(pll_s) |=> ev_flag[EV_PLL])
    else $error("pll fault not set");
  chk_pll_hold: assert property (ev_flag[EV_PLL] && !pll_ack |=> ev_flag[EV_PLL])
    else $error("pll fault dropped without acknowledge");
  chk_irq_hold: assert property (PSM_IRQ && !fl_wr_en[FL_PSM] |=> psm_q && PSM_IRQ)
    else $error("irq dropped without write");
  chk_flag_hold: assert property (ev_flag[EV_SAG] && !fl_wr_en[FL_SAG] |=> ev_flag[EV_SAG])
    else $error("sag flag dropped without write");
  chk_restore_hold: assert property (ev_flag[EV_RESTORED] && !fl_wr_en[FL_RESTORED] |=> ev_flag[EV_RESTORED])
    else $error("restore flag dropped without write");
  chk_set_once: assert property ($stable(sag_s) && !ev_flag[EV_SAG] && !fl_wr_en[FL_SAG] |=> !ev_flag[EV_SAG])
    else $error("sag flag set without edge");
  chk_rsvd_read: assert property (SFR_RD && SFR_ADDR == ADDR_FLAGS |=> SFR_RDATA[4:2] == 3'h0)
    else $error("reserved flag bits not zero");

  cov_restore_irq: cover property (ev_set[EV_RESTORED] && en_q[FL_RESTORED] ##2 PSM_IRQ);
  cov_battery: cover property ($fell(src_main_s) ##1 ev_flag[EV_BATTERY]);
  cov_rx_wake: cover property (ev_set[EV_RX]);
  cov_pll_ack: cover property (ev_flag[EV_PLL] ##1 pll_ack);
  cov_dcin_irq: cover property (ev_set[EV_DCIN] && en_q[FL_DCIN] ##1 PSM_IRQ);
endmodule // pef_power_events

// ### bench/tb_pef_power_events.sv
// Self-checking testbench of the power event flag block.
`timescale 1ns/100ps
module tb_pef_power_events;
  import pef_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, bwr = 1'b0, bval = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, baddr = 8'h00, rdata;
  logic src = 1'b1, mok = 1'b1, sag = 1'b0, dcl = 1'b0, pll = 1'b1, rxp = 1'b1, dsl = 1'b0;
  logic irq, low_main, low_dcin, rx_ser, rx_wake;
  int miscompares = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  pef_power_events dut_u (.REF_CLK(clk), .ARST_N(arst_n), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd),
    .SFR_WDATA(wdata), .SFR_BIT_WR(bwr), .SFR_BIT_ADDR(baddr), .SFR_BIT_VAL(bval), .SRC_IS_MAIN(src),
    .MAIN_SUPPLY_OK(mok), .SAG_DETECT(sag), .DCIN_LOW(dcl), .PLL_LOCKED(pll), .RX_PIN(rxp),
    .IN_DEEP_SLEEP(dsl), .SFR_RDATA(rdata), .PSM_IRQ(irq), .SWITCH_ON_LOW_MAIN(low_main),
    .SWITCH_ON_LOW_DCIN(low_dcin), .RX_SERIAL_SEL(rx_ser), .RX_WAKE_EN(rx_wake));
  // ****************************************
  // Shared bus and compare tasks.
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic wbit(input logic [7:0] a, input logic v);
    @(posedge clk);
    bwr <= 1'b1;
    baddr <= a;
    bval <= v;
    @(posedge clk);
    bwr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [7:0] b1(input logic v);
    return {7'h00, v};
  endfunction
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic t_reset;
    logic [7:0] d;
    rreg(ADDR_ENABLE, d); chk(d, 8'h00);
    rreg(ADDR_POLICY, d); chk(d, 8'h00);
    rreg(ADDR_FLAGS, d); chk(d, 8'h00);
    rreg(ADDR_PERIPHERAL_STATUS_CONFIG, d); chk(d, 8'h60);
    rreg(8'h80, d); chk(d, 8'h00);
    chk({irq, low_main, low_dcin, rx_ser, rx_wake}, 8'h08);
  endtask
  task automatic t_config;
    logic [7:0] d;
    logic [1:0] rf [3] = '{2'h0, 2'h1, 2'h3};
    wreg(ADDR_ENABLE, 8'hA3); rreg(ADDR_ENABLE, d); chk(d, 8'hA3);
    wreg(ADDR_ENABLE, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wreg(ADDR_POLICY, 8'(p)); cyc(2);
      rreg(ADDR_POLICY, d); chk(d, 8'(p));
      chk({low_main, low_dcin}, {6'h00, p < 2, p == 1});
    end
    for (int i = 0; i < 3; i++) begin
      wreg(ADDR_PERIPHERAL_STATUS_CONFIG, {6'h00, rf[i]}); cyc(2);
      chk({rx_ser, rx_wake}, {6'h00, rf[i][0], rf[i] == 2'h3});
    end
    wreg(ADDR_POLICY, 8'h00);
    wreg(ADDR_PERIPHERAL_STATUS_CONFIG, 8'h00);
  endtask
  task automatic t_sag;
    logic [7:0] d;
    wreg(ADDR_ENABLE, 8'h20);
    sag <= 1'b1; cyc(8);
    rreg(ADDR_FLAGS, d); chk(d, 8'h60);
    chk(b1(irq), 8'h01);
    wreg(ADDR_FLAGS, 8'h00); cyc(8);
    rreg(ADDR_FLAGS, d); chk(d, 8'h00);
    chk(b1(irq), 8'h00);
    sag <= 1'b0; cyc(8);
  endtask
  task automatic t_switch;
    logic [7:0] d;
    wreg(ADDR_ENABLE, 8'h02);
    src <= 1'b0; cyc(8);
    rreg(ADDR_FLAGS, d); chk(d, 8'h42);
    rreg(ADDR_PERIPHERAL_STATUS_CONFIG, d); chk(d, 8'h20);
    wbit(8'hF9, 1'b0); wbit(8'hFE, 1'b0); cyc(3);
    rreg(ADDR_FLAGS, d); chk(d, 8'h00);
    chk(b1(irq), 8'h00);
    wbit(8'hFD, 1'b1); cyc(1);
    rreg(ADDR_FLAGS, d); chk(d, 8'h20);
    chk(b1(irq), 8'h00);
    wbit(8'hFD, 1'b0); cyc(1);
    rreg(ADDR_FLAGS, d); chk(d, 8'h00);
    src <= 1'b1; cyc(8);
    rreg(ADDR_FLAGS, d); chk(d, 8'h80);
    wreg(ADDR_FLAGS, 8'h00);
    wreg(ADDR_ENABLE, 8'h80);
    src <= 1'b0; cyc(8); src <= 1'b1; cyc(8);
    rreg(ADDR_FLAGS, d); chk(d, 8'hC2);
    wreg(ADDR_FLAGS, 8'h00);
    wreg(ADDR_ENABLE, 8'h01);
    dcl <= 1'b1; cyc(8);
    rreg(ADDR_FLAGS, d); chk(d, 8'h41);
    chk(b1(irq), 8'h01);
    dcl <= 1'b0;
    wreg(ADDR_FLAGS, 8'h00);
    wreg(ADDR_ENABLE, 8'h00);
  endtask
  task automatic t_peripheral_status_config;
    logic [7:0] d;
    pll <= 1'b0; cyc(8);
    pll <= 1'b1; cyc(8);
    rreg(ADDR_PERIPHERAL_STATUS_CONFIG, d); chk(d, 8'h70);
    wreg(ADDR_MEAS_START, 8'h40);
    rreg(ADDR_PERIPHERAL_STATUS_CONFIG, d); chk(d, 8'h60);
    mok <= 1'b0; cyc(8);
    rreg(ADDR_PERIPHERAL_STATUS_CONFIG, d); chk(d, 8'h40);
    mok <= 1'b1;
    wreg(ADDR_PERIPHERAL_STATUS_CONFIG, 8'h01);
    dsl <= 1'b1; rxp <= 1'b0; cyc(8);
    rreg(ADDR_PERIPHERAL_STATUS_CONFIG, d); chk(d, 8'h61);
    rxp <= 1'b1;
    wreg(ADDR_PERIPHERAL_STATUS_CONFIG, 8'h03); cyc(8);
    rxp <= 1'b0; cyc(8);
    rreg(ADDR_PERIPHERAL_STATUS_CONFIG, d); chk(d, 8'hE3);
    rxp <= 1'b1; dsl <= 1'b0;
    wreg(ADDR_PERIPHERAL_STATUS_CONFIG, 8'h03);
    rreg(ADDR_PERIPHERAL_STATUS_CONFIG, d); chk(d, 8'h63);
  endtask
  // ****************************************
  // Run control.
  // ****************************************
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    cyc(1);
    t_reset;
    t_config;
    t_sag;
    t_switch;
    t_peripheral_status_config;
    wrap_up;
  end
endmodule // tb_pef_power_events
